// file: udc_dma_pkg.sv
// Constants, states and carriers shared by the USB device DMA channel files
package udc_dma_pkg;
    localparam int          NCH       = 7;
    localparam logic [11:0] OFF_NEXT  = 12'h310;
    localparam logic [11:0] OFF_ADDR  = 12'h314;
    localparam logic [11:0] OFF_CTRL  = 12'h318;
    localparam logic [11:0] OFF_STAT  = 12'h31c;
    localparam logic [11:0] CH_STRIDE = 12'h010;
    localparam logic [11:0] MAP_SPAN  = 12'h070;
    localparam logic [1:0]  SUB_NEXT  = 2'h0;
    localparam logic [1:0]  SUB_ADDR  = 2'h1;
    localparam logic [1:0]  SUB_CTRL  = 2'h2;
    localparam logic [1:0]  SUB_STAT  = 2'h3;
    // Control field positions
    localparam int CTL_CHANNEL_ENABLE   = 0;
    localparam int CTL_LINK   = 1;
    localparam int CTL_BCLOSE = 2;
    localparam int CTL_EOBOUT = 3;
    localparam int CTL_EOTIE  = 4;
    localparam int CTL_EOBIE  = 5;
    localparam int CTL_DLIE   = 6;
    localparam int CTL_LOCK   = 7;
    localparam int LEN_LSB    = 16;
    // Status field positions
    localparam int STA_CHANNEL_ENABLE   = 0;
    localparam int STA_ACT    = 1;
    localparam int STA_EOT    = 4;
    localparam int STA_EOB    = 5;
    localparam int STA_DL     = 6;
    localparam int CNT_LSB    = 16;
    localparam int PTR_LSB    = 4;
    // Reset values and sizes
    localparam logic [31:0] RST_WORD  = 32'h0000_0000;
    localparam logic [16:0] LEN_MAX   = 17'h1_0000;
    localparam logic [2:0]  WORD_BYTES = 3'h4;
    localparam logic [1:0]  DESC_LAST = 2'h2;
    localparam logic [31:0] DESC_STEP = 32'h0000_0004;

    typedef enum logic [5:0] {
        S_IDLE   = 6'b000001,
        S_DESC   = 6'b000010,
        S_DWAIT  = 6'b000100,
        S_BUSWR  = 6'b001000,
        S_BUSRD  = 6'b010000,
        S_RDWAIT = 6'b100000
    } udc_state_e;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        logic [3:0]  be;
        logic        write;
        logic        req;
        logic        lock;
    } udc_sbreq_s;

    typedef struct packed {
        logic [2:0]  ch;
        logic        rd;
        logic        wr;
        logic [31:0] wdata;
        logic [3:0]  be;
    } udc_epout_s;
endpackage : udc_dma_pkg

// file: udc_flag.sv
// Sticky status flag, set by hardware and cleared by a status read
`timescale 1ns/1ns
`default_nettype none
module udc_flag (
    input  wire logic clk,    // Controller clock
    input  wire logic rst_n,  // Synchronous reset, active low
    input  wire logic set,    // Event pulse
    input  wire logic clr,    // Read clear pulse
    output logic      q       // Flag value
);
    logic q_next;

    // Set wins so an event in the read cycle is not lost
    always_comb begin
        q_next = set | (q & ~clr);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) q <= 1'b0;
        else        q <= q_next;
    end
endmodule : udc_flag
`default_nettype wire

// file: udc_beat.sv
// Byte count and lane enables of one word access from address and remaining count
`timescale 1ns/1ns
`default_nettype none
module udc_beat
    import udc_dma_pkg::*;
(
    input  wire logic [1:0]  off,    // Low address bits
    input  wire logic [16:0] rem,    // Bytes still to move
    output logic      [2:0]  nbytes, // Bytes in this access
    output logic      [3:0]  be      // Byte lanes used
);
    logic [3:0] mask;

    // Short access at unaligned start, or where the buffer ends
    always_comb begin
        nbytes = WORD_BYTES - {1'b0, off};
        if (rem < {14'h0, nbytes}) nbytes = rem[2:0];
        mask = 4'((5'h01 << nbytes) - 5'h01);
        be = 4'(mask << off);
    end
endmodule : udc_beat
`default_nettype wire

// file: udc_dma.sv
// Seven channel descriptor driven DMA engine between USB endpoint banks and the system bus
// What this block does
// - Next descriptor pointer keeps address bits 31:4 only; 16-byte aligned descriptors.
// - System bus address has its two low bits forced to zero.
// - Bus address advances by bytes moved at end of each address phase.
// - Accesses move four bytes, fewer at unaligned buffer start or end.
// - Transfer ends at buffer end, or USB transfer end with close-on-input.
// - Length zero, the reset value, means 64 kilobytes.
// - Length writes or loads ignored while channel enabled status is set.
// - Burst lock bit locks the bus during a data burst, else never.
// - Descriptor loaded interrupt when enabled, after each descriptor fetch.
// - End of buffer interrupt when enabled, as remaining count reaches zero.
// - End of transfer interrupt needs its enable and close-on-input both set.
// - End output option signals the endpoint at end of DMA transfer.
// - Close-on-input closes the transfer on a short OUT packet, except on high-speed isochronous.
// - High-speed isochronous: close when received PID is not MDATA.
// - Link and enable bits form a four way command.
// - Link set: next descriptor fetched after the transfer ends; else nothing reloads.
// - Enable cleared without link freezes the channel once status and active clear.
// - Writing enable one sets channel enabled status; pending requests then run.
// - Enable cleared mid service: internal word drains before status clears.
// - Link with enable zero skips the descriptor; next loads on endpoint request.
// - Remaining count decrements by the bytes moved on every data access.
// - Status flags set on events and clear when status is read.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module udc_dma
    import udc_dma_pkg::*;
(
    input  wire logic            CLOCK,        // 50 MHz controller clock
    input  wire logic            RST_N,        // Synchronous reset, active low
    input  wire logic [11:0]     REG_ADDR,     // Register byte address
    input  wire logic [31:0]     REG_WDATA,    // Register write data
    input  wire logic            REG_WR,       // Write strobe
    input  wire logic            REG_RD,       // Read strobe
    output logic      [31:0]     REG_RDATA,    // Read data, cycle after strobe
    output udc_sbreq_s           SB_OUT,       // System bus request
    input  wire logic            SB_GNT,       // Address phase taken
    input  wire logic            SB_RVALID,    // Read data valid
    input  wire logic [31:0]     SB_RDATA,     // Read data
    input  wire logic [NCH-1:0]  EP_REQ,       // Endpoint requests transfer
    input  wire logic [NCH-1:0]  EP_IS_IN,     // Endpoint direction is IN
    input  wire logic [NCH-1:0]  EP_SHORT_PKT, // Short OUT packet ended USB transfer
    input  wire logic [NCH-1:0]  EP_HS_ISO,    // High-speed isochronous endpoint
    input  wire logic [NCH-1:0]  EP_NOT_MDATA, // Packet PID was not MDATA
    input  wire logic [31:0]     EP_RDATA,     // Bank word for OUT endpoints
    output udc_epout_s           EP_OUT,       // Bank pop and push
    output logic      [NCH-1:0]  EP_END,       // End of DMA transfer pulse
    output logic      [NCH-1:0]  IRQ           // Channel interrupt lines
);
    logic [27:0]    nxt_reg [NCH];
    logic [27:0]    nxt_next[NCH];
    logic [31:0]    adr_reg [NCH];
    logic [31:0]    adr_next[NCH];
    logic [7:0]     ctl_reg [NCH];
    logic [7:0]     ctl_next[NCH];
    logic [15:0]    len_reg [NCH];
    logic [15:0]    len_next[NCH];
    logic [16:0]    rem_reg [NCH];
    logic [16:0]    rem_next[NCH];
    logic [NCH-1:0] chs_reg, chs_next, ldp_reg, ldp_next, ldi_reg, ldi_next;
    logic [NCH-1:0] set_dl, set_eob, set_eot, dl_q, eob_q, eot_q, rd_clr, act;
    logic [NCH-1:0] end_next, irq_next, cand;
    logic [31:0]    rdata_next;
    udc_state_e     st_reg, st_next;
    logic [2:0]     sel_reg, sel_next, pick, bsel;
    logic [31:0]    fifo_reg, fifo_next;
    logic [2:0]     nb_reg, nb_next, bt_nb;
    logic [1:0]     dcnt_reg, dcnt_next;
    logic [3:0]     bt_be;
    udc_sbreq_s     sb_next;
    udc_epout_s     ep_next;
    logic           ev_beat, ev_dword, any_cand;
    logic [11:0]    roff;
    logic           hit;
    logic [2:0]     ach;
    logic [1:0]     asub;

    // Register decode: seven groups at a fixed stride
    assign roff = REG_ADDR - OFF_NEXT;
    assign hit  = (REG_ADDR >= OFF_NEXT) && (roff < MAP_SPAN);
    assign ach  = roff[6:4];
    assign asub = roff[3:2];

    // One beat calculator, fed by the channel being picked or served
    assign bsel = (st_reg == S_IDLE) ? pick : sel_reg;
    udc_beat u_beat (
        .off    (adr_reg[bsel][1:0]),
        .rem    (rem_reg[bsel]),
        .nbytes (bt_nb),
        .be     (bt_be)
    );

    // Per channel sticky flags
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_flag
            udc_flag u_dl  (.clk(CLOCK), .rst_n(RST_N), .set(set_dl[g]),  .clr(rd_clr[g]), .q(dl_q[g]));
            udc_flag u_eob (.clk(CLOCK), .rst_n(RST_N), .set(set_eob[g]), .clr(rd_clr[g]), .q(eob_q[g]));
            udc_flag u_eot (.clk(CLOCK), .rst_n(RST_N), .set(set_eot[g]), .clr(rd_clr[g]), .q(eot_q[g]));
        end
    endgenerate

    // Arbitration: lowest channel with a pending load or an enabled request
    always_comb begin
        pick = 3'h0;
        any_cand = 1'b0;
        for (int i = NCH - 1; i >= 0; i--) begin
            cand[i] = (ldp_reg[i] & (ldi_reg[i] | EP_REQ[i]))
                    | (EP_REQ[i] & ctl_reg[i][CTL_CHANNEL_ENABLE] & chs_reg[i]);
            if (cand[i]) begin
                pick = 3'(i);
                any_cand = 1'b1;
            end
        end
    end

    // Engine next state: descriptor fetch and one word beat at a time
    always_comb begin
        st_next   = st_reg;
        sel_next  = sel_reg;
        fifo_next = fifo_reg;
        nb_next   = nb_reg;
        dcnt_next = dcnt_reg;
        sb_next   = SB_OUT;
        ep_next   = EP_OUT;
        ep_next.rd = 1'b0;
        ep_next.wr = 1'b0;
        ev_beat   = 1'b0;
        ev_dword  = 1'b0;
        case (st_reg)
            S_IDLE: begin
                // Lock survives the gap between beats of one burst only
                sb_next.lock = SB_OUT.lock & EP_REQ[sel_reg] & ctl_reg[sel_reg][CTL_CHANNEL_ENABLE];
                if (any_cand) begin
                    sel_next = pick;
                    ep_next.ch = pick;
                    nb_next = bt_nb;
                    sb_next.be = bt_be;
                    sb_next.req = 1'b1;
                    if (ldp_reg[pick]) begin
                        dcnt_next = 2'h0;
                        sb_next.addr = {nxt_reg[pick], 4'h0};
                        sb_next.write = 1'b0;
                        sb_next.be = 4'hf;
                        sb_next.lock = 1'b0;
                        st_next = S_DESC;
                    end else begin
                        sb_next.addr = {adr_reg[pick][31:2], 2'b00};
                        sb_next.lock = ctl_reg[pick][CTL_LOCK];
                        if (EP_IS_IN[pick]) begin
                            sb_next.write = 1'b0;
                            st_next = S_BUSRD;
                        end else begin
                            // Pop the bank word into the holding register
                            ep_next.rd = 1'b1;
                            fifo_next = EP_RDATA;
                            sb_next.wdata = EP_RDATA;
                            sb_next.write = 1'b1;
                            st_next = S_BUSWR;
                        end
                    end
                end
            end
            S_DESC: begin
                if (SB_GNT) begin
                    sb_next.req = 1'b0;
                    st_next = S_DWAIT;
                end
            end
            S_DWAIT: begin
                if (SB_RVALID) begin
                    ev_dword = 1'b1;
                    if (dcnt_reg == DESC_LAST) begin
                        st_next = S_IDLE;
                    end else begin
                        dcnt_next = dcnt_reg + 2'h1;
                        sb_next.addr = SB_OUT.addr + DESC_STEP;
                        sb_next.req = 1'b1;
                        st_next = S_DESC;
                    end
                end
            end
            S_BUSWR: begin
                if (SB_GNT) begin
                    ev_beat = 1'b1;
                    sb_next.req = 1'b0;
                    st_next = S_IDLE;
                end
            end
            S_BUSRD: begin
                if (SB_GNT) begin
                    ev_beat = 1'b1;
                    sb_next.req = 1'b0;
                    st_next = S_RDWAIT;
                end
            end
            S_RDWAIT: begin
                // The held word is always pushed to the bank in the same cycle the engine returns to idle
                if (SB_RVALID) begin
                    fifo_next = SB_RDATA;
                    ep_next.wr = 1'b1;
                    ep_next.wdata = SB_RDATA;
                    ep_next.be = SB_OUT.be;
                    st_next = S_IDLE;
                end
            end
            default: begin
                st_next = S_IDLE;
                sb_next.req = 1'b0;
                sb_next.lock = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            st_reg   <= S_IDLE;
            sel_reg  <= 3'h0;
            fifo_reg <= RST_WORD;
            nb_reg   <= 3'h0;
            dcnt_reg <= 2'h0;
            SB_OUT   <= '0;
            EP_OUT   <= '0;
        end else begin
            st_reg   <= st_next;
            sel_reg  <= sel_next;
            fifo_reg <= fifo_next;
            nb_reg   <= nb_next;
            dcnt_reg <= dcnt_next;
            SB_OUT   <= sb_next;
            EP_OUT   <= ep_next;
        end
    end

    // Channel registers: software access, descriptor loads, beats and closes
    always_comb begin
        rdata_next = RST_WORD;
        for (int i = 0; i < NCH; i++) begin
            logic sw, close, eob;
            sw = REG_WR && hit && (ach == 3'(i));
            close = 1'b0;
            eob = 1'b0;
            nxt_next[i] = nxt_reg[i];
            adr_next[i] = adr_reg[i];
            ctl_next[i] = ctl_reg[i];
            len_next[i] = len_reg[i];
            rem_next[i] = rem_reg[i];
            chs_next[i] = chs_reg[i];
            ldp_next[i] = ldp_reg[i];
            ldi_next[i] = ldi_reg[i];
            set_dl[i] = 1'b0;
            set_eob[i] = 1'b0;
            set_eot[i] = 1'b0;
            end_next[i] = 1'b0;
            act[i] = (st_reg != S_IDLE) && (sel_reg == 3'(i));
            rd_clr[i] = REG_RD && hit && (ach == 3'(i)) && (asub == SUB_STAT);
            if (sw && asub == SUB_NEXT) nxt_next[i] = REG_WDATA[31:PTR_LSB];
            if (sw && asub == SUB_ADDR) adr_next[i] = REG_WDATA;
            if (sw && asub == SUB_CTRL) begin
                ctl_next[i] = REG_WDATA[7:0];
                if (!chs_reg[i]) begin
                    len_next[i] = REG_WDATA[31:LEN_LSB];
                    rem_next[i] = (REG_WDATA[31:LEN_LSB] == 16'h0) ? LEN_MAX : {1'b0, REG_WDATA[31:LEN_LSB]};
                end
                if (REG_WDATA[CTL_CHANNEL_ENABLE]) chs_next[i] = 1'b1;
                // Command decode on link and enable
                ldp_next[i] = REG_WDATA[CTL_LINK] & ~REG_WDATA[CTL_CHANNEL_ENABLE];
                ldi_next[i] = 1'b0;
            end
            if (ev_dword && sel_reg == 3'(i)) begin
                case (dcnt_reg)
                    2'h0:    nxt_next[i] = SB_RDATA[31:PTR_LSB];
                    2'h1:    adr_next[i] = SB_RDATA;
                    default: begin
                        ctl_next[i] = SB_RDATA[7:0];
                        len_next[i] = SB_RDATA[31:LEN_LSB];
                        rem_next[i] = (SB_RDATA[31:LEN_LSB] == 16'h0) ? LEN_MAX : {1'b0, SB_RDATA[31:LEN_LSB]};
                        chs_next[i] = SB_RDATA[CTL_CHANNEL_ENABLE];
                        ldp_next[i] = SB_RDATA[CTL_LINK] & ~SB_RDATA[CTL_CHANNEL_ENABLE];
                        ldi_next[i] = 1'b0;
                        set_dl[i] = 1'b1;
                    end
                endcase
            end
            if (ev_beat && sel_reg == 3'(i)) begin
                adr_next[i] = adr_reg[i] + 32'(nb_reg);
                rem_next[i] = rem_reg[i] - 17'(nb_reg);
                eob = (rem_reg[i] == 17'(nb_reg));
            end
            // Close on short packet when not high-speed isochronous, or on non-MDATA PID when it is
            close = chs_reg[i] & ctl_reg[i][CTL_BCLOSE]
                  & ((EP_SHORT_PKT[i] & ~EP_HS_ISO[i])
                  |  (EP_HS_ISO[i] & EP_NOT_MDATA[i]));
            if (eob || close) begin
                set_eob[i] = eob;
                set_eot[i] = close & ~eob;
                chs_next[i] = 1'b0;
                ctl_next[i][CTL_CHANNEL_ENABLE] = 1'b0;
                end_next[i] = ctl_reg[i][CTL_EOBOUT];
                ldp_next[i] = ctl_reg[i][CTL_LINK];
                ldi_next[i] = ctl_reg[i][CTL_LINK];
            end
            // Disabled channel stops only after its held word is out
            if (!ctl_next[i][CTL_CHANNEL_ENABLE] && !act[i] && !(ev_dword && sel_reg == 3'(i))) begin
                chs_next[i] = 1'b0;
            end
            irq_next[i] = (dl_q[i] & ctl_reg[i][CTL_DLIE])
                        | (eob_q[i] & ctl_reg[i][CTL_EOBIE])
                        | (eot_q[i] & ctl_reg[i][CTL_EOTIE] & ctl_reg[i][CTL_BCLOSE]);
        end
        if (REG_RD && hit) begin
            case (asub)
                SUB_NEXT: rdata_next = {nxt_reg[ach], 4'h0};
                SUB_ADDR: rdata_next = adr_reg[ach];
                SUB_CTRL: rdata_next = {len_reg[ach], 8'h00, ctl_reg[ach]};
                default:  rdata_next = {rem_reg[ach][15:0], 9'h000, dl_q[ach], eob_q[ach], eot_q[ach],
                                        2'b00, act[ach], chs_reg[ach]};
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            for (int i = 0; i < NCH; i++) begin
                nxt_reg[i] <= 28'h0;
                adr_reg[i] <= RST_WORD;
                ctl_reg[i] <= 8'h00;
                len_reg[i] <= 16'h0;
                rem_reg[i] <= LEN_MAX;
            end
            chs_reg   <= '0;
            ldp_reg   <= '0;
            ldi_reg   <= '0;
            EP_END    <= '0;
            IRQ       <= '0;
            REG_RDATA <= RST_WORD;
        end else begin
            nxt_reg   <= nxt_next;
            adr_reg   <= adr_next;
            ctl_reg   <= ctl_next;
            len_reg   <= len_next;
            rem_reg   <= rem_next;
            chs_reg   <= chs_next;
            ldp_reg   <= ldp_next;
            ldi_reg   <= ldi_next;
            EP_END    <= end_next;
            IRQ       <= irq_next;
            REG_RDATA <= rdata_next;
        end
    end

    // Checks on the engine and register behaviour
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    logic [31:0] cur_adr;
    logic [16:0] cur_rem;
    assign cur_adr = adr_reg[sel_reg];
    assign cur_rem = rem_reg[sel_reg];
    sequence s_last_word;
        (st_reg == S_DWAIT) && SB_RVALID && (dcnt_reg == DESC_LAST);
    endsequence
    sequence s_ctl_write;
        REG_WR && hit && (asub == SUB_CTRL);
    endsequence

    property p_word_addr;
        SB_OUT.req |-> (SB_OUT.addr[1:0] == 2'b00);
    endproperty
    a_word_addr: assert property (p_word_addr) else $error("bus address not word aligned");
    property p_be_width;
        (SB_OUT.req && st_reg != S_DESC) |-> ($countones(SB_OUT.be) == 32'(nb_reg)) && (nb_reg != 3'h0);
    endproperty
    a_be_width: assert property (p_be_width) else $error("byte lanes differ from beat size");
    property p_beat_adr;
        ev_beat |=> (cur_adr == $past(cur_adr) + 32'($past(nb_reg)));
    endproperty
    a_beat_adr: assert property (p_beat_adr) else $error("address did not advance by beat");
    property p_beat_rem;
        ev_beat |=> (cur_rem == $past(cur_rem) - 17'($past(nb_reg)));
    endproperty
    a_beat_rem: assert property (p_beat_rem) else $error("remaining count did not decrement");
    property p_lock;
        SB_OUT.lock |-> ctl_reg[sel_reg][CTL_LOCK];
    endproperty
    a_lock: assert property (p_lock) else $error("bus locked with lock disabled");
    property p_desc_flag;
        s_last_word ##1 (!rd_clr[sel_reg]) |-> dl_q[sel_reg];
    endproperty
    a_desc_flag: assert property (p_desc_flag) else $error("descriptor flag not set");
    property p_len_hold;
        (s_ctl_write and chs_reg[ach]) |=> (len_reg[$past(ach)] == $past(len_reg[ach]));
    endproperty
    a_len_hold: assert property (p_len_hold) else $error("length changed while enabled");
    property p_zero_len;
        (s_ctl_write and !chs_reg[ach] && REG_WDATA[31:LEN_LSB] == 16'h0) |=> (rem_reg[$past(ach)] == LEN_MAX);
    endproperty
    a_zero_len: assert property (p_zero_len) else $error("zero length is not maximum");
    property p_channel_enable_set;
        (s_ctl_write and REG_WDATA[CTL_CHANNEL_ENABLE]) |=> chs_reg[$past(ach)];
    endproperty
    a_channel_enable_set: assert property (p_channel_enable_set) else $error("enable write did not set status");
    property p_drain;
        (act[sel_reg] && chs_reg[sel_reg] && !set_eob[sel_reg] && !set_eot[sel_reg] && !ev_dword)
            |=> chs_reg[$past(sel_reg)];
    endproperty
    a_drain: assert property (p_drain) else $error("status cleared before drain");
endmodule : udc_dma
`default_nettype wire

// file: udc_mem_model.sv
// System memory model answering the channel's word accesses
`timescale 1ns/1ns
`default_nettype none
module udc_mem_model
    import udc_dma_pkg::*;
(
    input  wire logic        clk,    // Controller clock
    input  wire udc_sbreq_s  sb_req, // Request from the channel
    output logic             gnt,    // Address phase taken
    output logic             rvalid, // Read data valid
    output logic      [31:0] rdata   // Read data, scrambled when not valid
);
    logic [31:0] mem [0:15];
    logic        rd_pend;
    initial begin
        gnt = 1'b0;
        rvalid = 1'b0;
        rdata = 32'h0000_0000;
        rd_pend = 1'b0;
    end
    // Grant one cycle late so requests must hold; reads answer after a wait
    always @(posedge clk) begin
        gnt <= sb_req.req && !gnt;
        rd_pend <= sb_req.req && !gnt && !sb_req.write;
        rvalid <= rd_pend;
        rdata <= rd_pend ? mem[sb_req.addr[5:2]] : ~rdata; // Never hold a stale word
        if (sb_req.req && !gnt && sb_req.write) begin
            for (int i = 0; i < 4; i++) begin
                if (sb_req.be[i]) mem[sb_req.addr[5:2]][8*i +: 8] <= sb_req.wdata[8*i +: 8];
            end
        end
    end
endmodule : udc_mem_model
`default_nettype wire

// file: tb.sv
// Self-checking bench for the USB device DMA channels
`timescale 1ns/1ns
`default_nettype none
module tb
    import udc_dma_pkg::*;
;
    logic CLOCK = 1'b0, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, SB_GNT, SB_RVALID;
    logic [11:0] REG_ADDR = 12'h000;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, SB_RDATA, EP_RDATA = 32'hddcc_bbaa;
    logic [NCH-1:0] EP_REQ = 7'h00, EP_END, IRQ, EP_IS_IN = 7'h00, EP_SHORT_PKT = 7'h00;
    logic [NCH-1:0] EP_HS_ISO = 7'h00, EP_NOT_MDATA = 7'h00;
    udc_sbreq_s SB_OUT;
    udc_epout_s EP_OUT;
    int miscompares = 0, cmp_count = 0;
    always #10 CLOCK = ~CLOCK;
    udc_dma DUT (.CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
        .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .SB_OUT(SB_OUT), .SB_GNT(SB_GNT),
        .SB_RVALID(SB_RVALID), .SB_RDATA(SB_RDATA), .EP_REQ(EP_REQ), .EP_IS_IN(EP_IS_IN),
        .EP_SHORT_PKT(EP_SHORT_PKT), .EP_HS_ISO(EP_HS_ISO), .EP_NOT_MDATA(EP_NOT_MDATA), .EP_RDATA(EP_RDATA),
        .EP_OUT(EP_OUT), .EP_END(EP_END), .IRQ(IRQ));
    udc_mem_model MEM (.clk(CLOCK), .sb_req(SB_OUT), .gnt(SB_GNT), .rvalid(SB_RVALID), .rdata(SB_RDATA));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge CLOCK) {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
        @(posedge CLOCK) REG_WR <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] m, output logic [31:0] v);
        @(posedge CLOCK) {REG_RD, REG_ADDR} <= {1'b1, a};
        @(posedge CLOCK) REG_RD <= 1'b0;
        #1 v = REG_RDATA & m;
    endtask : rd
    task automatic print_verdict;
        $display("mismatches %0d of %0d compares", miscompares, cmp_count);
        if (miscompares == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict
    // Wait for one granted access and check its word address and lanes
    task automatic beat(input logic [31:0] a, input logic [3:0] be);
        int n;
        for (n = 0; n < 200 && !(SB_OUT.req && SB_GNT); n++) @(posedge CLOCK) #1;
        if (n == 200) begin miscompares++; print_verdict(); end
        chk(SB_OUT.addr, a);
        chk({28'h0, SB_OUT.be}, {28'h0, be});
        @(posedge CLOCK) #1;
    endtask : beat
    // Reset values, pointer alignment, channel stride, unmapped place
    task automatic t_regs;
        logic [31:0] v;
        rd(OFF_STAT, 32'hffff_ffff, v); chk(v, RST_WORD);
        rd(OFF_CTRL, 32'hffff_ffff, v); chk(v, RST_WORD);
        wr(12'h370, 32'h1234_567f); rd(12'h370, 32'hffff_ffff, v); chk(v, 32'h1234_5670);
        rd(OFF_NEXT, 32'hffff_ffff, v); chk(v, RST_WORD);
        wr(12'h380, 32'hffff_ffff); rd(12'h380, 32'hffff_ffff, v); chk(v, 32'h0);
    endtask : t_regs
    // Unaligned four byte OUT buffer with end output and end of buffer interrupt
    task automatic t_out;
        logic [31:0] v;
        int n;
        wr(OFF_ADDR, 32'h0000_1001);
        wr(OFF_CTRL, 32'h0004_ff29); rd(OFF_STAT, 32'h1, v); chk(v, 32'h1);
        wr(OFF_CTRL, 32'h0008_0029); rd(OFF_CTRL, 32'hffff_ffff, v); chk(v, 32'h0004_0029);
        @(posedge CLOCK) EP_REQ <= 7'h01;
        beat(32'h0000_1000, 4'he);
        beat(32'h0000_1004, 4'h1);
        for (n = 0; n < 200 && EP_END[0] !== 1'b1; n++) @(posedge CLOCK) #1;
        chk({31'h0, EP_END[0]}, 32'h1);
        @(posedge CLOCK) EP_REQ <= 7'h00;
        repeat (3) @(posedge CLOCK);
        chk({25'h0, IRQ}, 32'h1);
        rd(OFF_STAT, 32'hffff_0071, v); chk(v, 32'h0000_0020);
        rd(OFF_STAT, 32'h0000_0071, v); chk(v, 32'h0);
        rd(OFF_ADDR, 32'hffff_ffff, v); chk(v, 32'h0000_1005);
        repeat (3) @(posedge CLOCK);
        chk({25'h0, IRQ}, 32'h0);
    endtask : t_out
    // Unaligned three byte IN buffer on channel 1, reading back the OUT bytes, with burst lock
    task automatic t_in;
        logic [31:0] v;
        int n;
        wr(OFF_ADDR + 12'h010, 32'h0000_1001);
        wr(OFF_CTRL + 12'h010, 32'h0003_0081);
        @(posedge CLOCK) {EP_IS_IN, EP_REQ} <= {7'h02, 7'h02};
        beat(32'h0000_1000, 4'he);
        chk({31'h0, SB_OUT.lock}, 32'h1);
        for (n = 0; n < 200 && EP_OUT.wr !== 1'b1; n++) @(posedge CLOCK) #1;
        chk({EP_OUT.wdata[31:8], EP_OUT.be, 1'b0, EP_OUT.ch}, 32'hddcc_bbe1);
        @(posedge CLOCK) EP_REQ <= 7'h00;
        rd(OFF_STAT + 12'h010, 32'hffff_0071, v); chk(v, 32'h0000_0020);
    endtask : t_in
    // Channel 2 closes on a short packet, but when high-speed isochronous only on a non-MDATA PID
    task automatic t_close;
        logic [31:0] v;
        wr(OFF_CTRL + 12'h020, 32'h0008_0015);
        @(posedge CLOCK) EP_SHORT_PKT <= 7'h04;
        @(posedge CLOCK) EP_SHORT_PKT <= 7'h00;
        repeat (2) @(posedge CLOCK);
        chk({25'h0, IRQ}, 32'h4);
        rd(OFF_STAT + 12'h020, 32'h71, v); chk(v, 32'h10);
        @(posedge CLOCK) EP_HS_ISO <= 7'h04;
        wr(OFF_CTRL + 12'h020, 32'h0008_0015);
        @(posedge CLOCK) EP_SHORT_PKT <= 7'h04;
        @(posedge CLOCK) EP_SHORT_PKT <= 7'h00;
        rd(OFF_STAT + 12'h020, 32'h71, v); chk(v, 32'h1);
        @(posedge CLOCK) EP_NOT_MDATA <= 7'h04;
        @(posedge CLOCK) EP_NOT_MDATA <= 7'h00;
        rd(OFF_STAT + 12'h020, 32'h71, v); chk(v, 32'h10);
    endtask : t_close
    // Reset for 12 cycles, then the scenarios
    initial begin
        repeat (12) @(posedge CLOCK);
        RST_N <= 1'b1;
        t_regs();
        t_out();
        t_in();
        t_close();
        print_verdict();
    end
endmodule : tb
`default_nettype wire
